// ==== logic/tlgc_top.sv ====
/*
 * Tracking loop gain configuration: AXI4-Lite register slave holding the
 * PI compensator gain fields, their decoders and the determination tick.
 * Assumes a synchronous 40 MHz clock domain shared with the bus master.
 */
`timescale 1ns/1ps

// Function
// - Integral gain code selects x1 default, x0.125 up to x16.
// - Determination period code selects 25 to 800 us, others 50 us.
// - Periods counted in clock cycles derived from clock rate.
// - Low gain code 1..12 gives x0.0625 doubling; others give x1.
// - High gain code 1..12 gives x0.0625 doubling; others give x32.
// - Reserved bits read reset value; software writes reset value.
// - Bandwidth mode bit picks individual fields or the preset field.
// - Preset field ignored unless bandwidth mode bit is one.
// - Method code selects 12-level, 7-level, 2-level AGC or fixed.
// - Preset codes map to 800/1500/1000/500/200 Hz or automatic.
module tlgc_top
   import tlgc_pkg::*;
#(
   parameter int DET_UNIT_CYC = tlgc_pkg::TLGC_DET_UNIT_CYC
)
(
   input wire logic REF_CLK_I,
   input wire logic RST_B_I,
   input wire logic [tlgc_pkg::TLGC_ADDR_W-1:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic [tlgc_pkg::TLGC_ADDR_W-1:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   output logic [3:0] GAIN_METHOD_O,
   output logic [3:0] INTEG_GAIN_EXP_O,
   output logic [3:0] LOW_KV_EXP_O,
   output logic [3:0] HIGH_KV_EXP_O,
   output logic [1:0] ERROR_WEIGHT_O,
   output logic [1:0] PROP_GAIN_O,
   output logic PROP_GAIN_QUAD_O,
   output logic COEF_FROM_PRESET_O,
   output logic [10:0] BANDWIDTH_HZ_O,
   output logic BANDWIDTH_AUTO_O,
   output logic PRESET_BAD_O,
   output logic OVERFLOW_RISK_O,
   output logic DET_TICK_O
);
   import tlgc_pkg::*;

   // ********************************************
   // Elaboration checks
   // ********************************************
   if (DET_UNIT_CYC < 1 || DET_UNIT_CYC * 32 >= (1 << TLGC_CNT_W))
   begin : g_bad_unit
      $error("DET_UNIT_CYC out of range");
   end

   // ********************************************
   // Decode functions
   // ********************************************
   // Signed power-of-two exponent of the integral gain
   function automatic logic [3:0] integ_exp(input logic [2:0] code);
      logic [3:0] e;
      e = 4'h0;
      case (code)
         3'h1: e = 4'hD;
         3'h2: e = 4'hE;
         3'h3: e = 4'hF;
         3'h4: e = 4'h1;
         3'h5: e = 4'h2;
         3'h6: e = 4'h3;
         3'h7: e = 4'h4;
         default: e = 4'h0;
      endcase
      return e;
   endfunction : integ_exp

   // Codes 1..12 map to exponents -4..7, others to a default
   function automatic logic [3:0] kv_exp(input logic [3:0] code, input logic [3:0] dflt);
      logic [3:0] e;
      e = dflt;
      if (code >= 4'h1 && code <= 4'hC)
      begin
         e = code - 4'h5;
      end
      return e;
   endfunction : kv_exp

   // Period length in units of 25 us
   function automatic logic [5:0] period_mult(input logic [2:0] code);
      logic [5:0] m;
      m = 6'h02;
      case (code)
         3'h1: m = 6'h04;
         3'h2: m = 6'h08;
         3'h3: m = 6'h01;
         3'h4: m = 6'h10;
         3'h5: m = 6'h20;
         default: m = 6'h02;
      endcase
      return m;
   endfunction : period_mult

   // Settings that would overflow the proportional path
   function automatic logic multi_bad(input logic [1:0] w, input logic [1:0] p, input logic q);
      logic b;
      b = 1'b0;
      if (q)
      begin
         b = (p == 2'h3) || (w != 2'h0 && p == 2'h0) || (w[1] && p == 2'h2);
      end
      else
      begin
         b = w[1] && p == 2'h3;
      end
      return b;
   endfunction : multi_bad

   // ********************************************
   // Register and field views
   // ********************************************
   logic [31:0] cfg_reg;
   logic [31:0] cfg_next;
   logic [31:0] stat_word;
   logic [1:0] method_code;
   logic [1:0] weight_code;
   logic [1:0] prop_code;
   logic quad_bit;
   logic [2:0] integ_code;
   logic [2:0] devwin_code;
   logic [3:0] lowkv_code;
   logic [3:0] highkv_code;
   logic bwmode_bit;
   logic [2:0] preset_code;

   assign method_code = cfg_reg[TLGC_METHOD_LSB +: 2];
   assign weight_code = cfg_reg[TLGC_WEIGHT_LSB +: 2];
   assign quad_bit = cfg_reg[TLGC_QUAD_BIT];
   assign prop_code = cfg_reg[TLGC_PROP_LSB +: 2];
   assign integ_code = cfg_reg[TLGC_INTEG_LSB +: 3];
   assign devwin_code = cfg_reg[TLGC_DEVWIN_LSB +: 3];
   assign lowkv_code = cfg_reg[TLGC_LOWKV_LSB +: 4];
   assign highkv_code = cfg_reg[TLGC_HIGHKV_LSB +: 4];
   assign bwmode_bit = cfg_reg[TLGC_BWMODE_BIT];
   assign preset_code = cfg_reg[TLGC_PRESET_LSB +: 3];

   // ********************************************
   // Decoded settings
   // ********************************************
   logic [3:0] method_dec;
   logic [10:0] bw_dec;
   logic bw_auto_dec;
   logic preset_bad_dec;
   logic ovf_dec;
   logic [TLGC_CNT_W-1:0] det_target;

   assign method_dec = (method_code == 2'h0) ? TLGC_AGC12 :
                       (method_code == 2'h1) ? TLGC_AGC7 :
                       (method_code == 2'h2) ? TLGC_AGC2 : TLGC_FIXED;

   assign bw_dec = !bwmode_bit ? 11'd0 :
                   (preset_code == 3'h0) ? TLGC_BW_800 :
                   (preset_code == 3'h3) ? TLGC_BW_1500 :
                   (preset_code == 3'h4) ? TLGC_BW_1000 :
                   (preset_code == 3'h5) ? TLGC_BW_500 :
                   (preset_code == 3'h6) ? TLGC_BW_200 : 11'd0;
   assign bw_auto_dec = bwmode_bit && preset_code == 3'h7;
   assign preset_bad_dec = bwmode_bit && (preset_code == 3'h1 || preset_code == 3'h2);

   // large high gain overflow set flagged
   assign ovf_dec = !method_code[1] ? multi_bad(weight_code, prop_code, quad_bit) :
      (highkv_code == 4'hC) ? multi_bad(weight_code, prop_code, quad_bit) :
      (highkv_code == 4'hB) ? (quad_bit && ((prop_code == 2'h3 && weight_code != 2'h0)
                                || (prop_code == 2'h0 && weight_code[1]))) :
      (highkv_code == 4'hA) ? (quad_bit && prop_code == 2'h3 && weight_code[1]) : 1'b0;

   assign det_target = TLGC_CNT_W'(DET_UNIT_CYC) * TLGC_CNT_W'(period_mult(devwin_code));

   // ********************************************
   // Decoded outputs and determination tick
   // ********************************************
   logic [TLGC_CNT_W-1:0] det_cnt_reg;
   logic [TLGC_CNT_W-1:0] det_cnt_next;
   logic det_wrap;

   assign det_wrap = det_cnt_reg >= det_target - TLGC_CNT_W'(1);
   assign det_cnt_next = det_wrap ? '0 : det_cnt_reg + TLGC_CNT_W'(1);

   always_ff @(posedge REF_CLK_I)
   begin
      if (!RST_B_I)
      begin
         det_cnt_reg <= '0;
         DET_TICK_O <= 1'b0;
      end
      else
      begin
         det_cnt_reg <= det_cnt_next;
         DET_TICK_O <= det_wrap;
      end
   end

   // Outputs lag the register by one cycle to stay flop-driven
   always_ff @(posedge REF_CLK_I)
   begin
      if (!RST_B_I)
      begin
         GAIN_METHOD_O <= TLGC_AGC12;
         INTEG_GAIN_EXP_O <= 4'h0;
         LOW_KV_EXP_O <= TLGC_LOWKV_DFLT_EXP;
         HIGH_KV_EXP_O <= TLGC_HIGHKV_DFLT_EXP;
         ERROR_WEIGHT_O <= 2'h0;
         PROP_GAIN_O <= 2'h0;
         PROP_GAIN_QUAD_O <= 1'b0;
         COEF_FROM_PRESET_O <= 1'b1;
         BANDWIDTH_HZ_O <= TLGC_BW_800;
         BANDWIDTH_AUTO_O <= 1'b0;
         PRESET_BAD_O <= 1'b0;
         OVERFLOW_RISK_O <= 1'b0;
      end
      else
      begin
         GAIN_METHOD_O <= method_dec;
         INTEG_GAIN_EXP_O <= integ_exp(integ_code);
         LOW_KV_EXP_O <= kv_exp(lowkv_code, TLGC_LOWKV_DFLT_EXP);
         HIGH_KV_EXP_O <= kv_exp(highkv_code, TLGC_HIGHKV_DFLT_EXP);
         ERROR_WEIGHT_O <= weight_code;
         PROP_GAIN_O <= prop_code;
         PROP_GAIN_QUAD_O <= quad_bit;
         COEF_FROM_PRESET_O <= bwmode_bit;
         BANDWIDTH_HZ_O <= bw_dec;
         BANDWIDTH_AUTO_O <= bw_auto_dec;
         PRESET_BAD_O <= preset_bad_dec;
         OVERFLOW_RISK_O <= ovf_dec;
      end
   end

   assign stat_word = {5'h00, BANDWIDTH_HZ_O, COEF_FROM_PRESET_O, BANDWIDTH_AUTO_O,
                       PRESET_BAD_O, OVERFLOW_RISK_O, HIGH_KV_EXP_O, LOW_KV_EXP_O,
                       INTEG_GAIN_EXP_O};

   // ********************************************
   // AXI4-Lite write channel
   // ********************************************
   tlgc_wr_e wr_state_reg;
   tlgc_wr_e wr_state_next;
   logic aw_got_reg;
   logic w_got_reg;
   logic [TLGC_ADDR_W-1:0] waddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic aw_fire;
   logic w_fire;
   logic wr_do;
   logic wr_hit;
   logic [31:0] strb_mask;

   assign aw_fire = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
   assign w_fire = S_AXI_WVALID_I && S_AXI_WREADY_O;
   assign wr_do = (wr_state_reg == TLGC_WR_IDLE) && aw_got_reg && w_got_reg;
   assign wr_hit = {waddr_reg[TLGC_ADDR_W-1:2], 2'h0} == TLGC_CFG_OFS;
   assign strb_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}},
                       {8{wstrb_reg[0]}}};
   assign wr_state_next = wr_do ? TLGC_WR_RESP :
      (wr_state_reg == TLGC_WR_RESP && S_AXI_BREADY_I) ? TLGC_WR_IDLE : wr_state_reg;

   assign cfg_next = (wr_do && wr_hit) ?
      ((cfg_reg & ~(strb_mask & TLGC_CFG_WMASK)) | (wdata_reg & strb_mask & TLGC_CFG_WMASK)) :
      cfg_reg;

   always_ff @(posedge REF_CLK_I)
   begin
      if (!RST_B_I)
      begin
         cfg_reg <= TLGC_CFG_RST;
         wr_state_reg <= TLGC_WR_IDLE;
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         waddr_reg <= '0;
         wdata_reg <= '0;
         wstrb_reg <= 4'h0;
         S_AXI_AWREADY_O <= 1'b0;
         S_AXI_WREADY_O <= 1'b0;
         S_AXI_BVALID_O <= 1'b0;
         S_AXI_BRESP_O <= TLGC_RESP_OKAY;
      end
      else
      begin
         cfg_reg <= cfg_next;
         wr_state_reg <= wr_state_next;
         if (aw_fire)
         begin
            waddr_reg <= S_AXI_AWADDR_I;
         end
         if (w_fire)
         begin
            wdata_reg <= S_AXI_WDATA_I;
            wstrb_reg <= S_AXI_WSTRB_I;
         end
         aw_got_reg <= !wr_do && (aw_got_reg || aw_fire);
         w_got_reg <= !wr_do && (w_got_reg || w_fire);
         S_AXI_AWREADY_O <= wr_state_next == TLGC_WR_IDLE && !wr_do && !aw_got_reg && !aw_fire;
         S_AXI_WREADY_O <= wr_state_next == TLGC_WR_IDLE && !wr_do && !w_got_reg && !w_fire;
         S_AXI_BVALID_O <= wr_state_next == TLGC_WR_RESP;
         if (wr_do)
         begin
            S_AXI_BRESP_O <= wr_hit ? TLGC_RESP_OKAY : TLGC_RESP_SLVERR;
         end
      end
   end

   // ********************************************
   // AXI4-Lite read channel
   // ********************************************
   tlgc_rd_e rd_state_reg;
   logic ar_fire;
   logic [TLGC_ADDR_W-1:0] raddr_word;
   logic rd_cfg;
   logic rd_stat;

   assign ar_fire = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
   assign raddr_word = {S_AXI_ARADDR_I[TLGC_ADDR_W-1:2], 2'h0};
   assign rd_cfg = raddr_word == TLGC_CFG_OFS;
   assign rd_stat = raddr_word == TLGC_STAT_OFS;

   always_ff @(posedge REF_CLK_I)
   begin
      if (!RST_B_I)
      begin
         rd_state_reg <= TLGC_RD_IDLE;
         S_AXI_ARREADY_O <= 1'b0;
         S_AXI_RVALID_O <= 1'b0;
         S_AXI_RDATA_O <= 32'h0000_0000;
         S_AXI_RRESP_O <= TLGC_RESP_OKAY;
      end
      else
      begin
         case (rd_state_reg)
            TLGC_RD_IDLE:
            begin
               S_AXI_ARREADY_O <= !ar_fire;
               if (ar_fire)
               begin
                  rd_state_reg <= TLGC_RD_RESP;
                  S_AXI_RVALID_O <= 1'b1;
                  // reserved bits read back reset value
                  if (rd_cfg)
                  begin
                     S_AXI_RDATA_O <= cfg_reg;
                     S_AXI_RRESP_O <= TLGC_RESP_OKAY;
                  end
                  else if (rd_stat)
                  begin
                     S_AXI_RDATA_O <= stat_word;
                     S_AXI_RRESP_O <= TLGC_RESP_OKAY;
                  end
                  else
                  begin
                     S_AXI_RDATA_O <= 32'h0000_0000;
                     S_AXI_RRESP_O <= TLGC_RESP_SLVERR;
                  end
               end
            end
            TLGC_RD_RESP:
            begin
               if (S_AXI_RREADY_I)
               begin
                  rd_state_reg <= TLGC_RD_IDLE;
                  S_AXI_RVALID_O <= 1'b0;
                  S_AXI_ARREADY_O <= 1'b1;
               end
            end
            default:
            begin
               rd_state_reg <= TLGC_RD_IDLE;
               S_AXI_RVALID_O <= 1'b0;
               S_AXI_ARREADY_O <= 1'b0;
            end
         endcase
      end
   end

endmodule : tlgc_top

// ==== common/tlgc_pkg.sv ====
/*
 * Constants for the tracking loop gain configuration block: register map,
 * field positions, reset values and determination period timing.
 * Assumes a single clock drives the block; period counts keep the 40 MHz
 * core reference rate, so a slower clock stretches them.
 */
package tlgc_pkg;

   // ********************************************
   // Bus and register map
   // ********************************************
   localparam int TLGC_ADDR_W = 8;
   localparam int TLGC_DATA_W = 32;
   localparam logic [7:0] TLGC_CFG_OFS = 8'h04;
   localparam logic [7:0] TLGC_STAT_OFS = 8'h08;
   localparam logic [31:0] TLGC_CFG_RST = 32'h0002_0010;
   // Reserved bits 27, 23, 19, 7..5 and 3 stay at reset value
   localparam logic [31:0] TLGC_CFG_WMASK = 32'hF777_FF17;
   localparam logic [1:0] TLGC_RESP_OKAY = 2'h0;
   localparam logic [1:0] TLGC_RESP_SLVERR = 2'h2;

   // ********************************************
   // Field positions in loop_gain_config
   // ********************************************
   localparam int TLGC_METHOD_LSB = 30;
   localparam int TLGC_WEIGHT_LSB = 28;
   localparam int TLGC_QUAD_BIT = 26;
   localparam int TLGC_PROP_LSB = 24;
   localparam int TLGC_INTEG_LSB = 20;
   localparam int TLGC_DEVWIN_LSB = 16;
   localparam int TLGC_LOWKV_LSB = 12;
   localparam int TLGC_HIGHKV_LSB = 8;
   localparam int TLGC_BWMODE_BIT = 4;
   localparam int TLGC_PRESET_LSB = 0;

   // ********************************************
   // Timing
   // ********************************************
   // Core reference rate; 50 us is 2000 cycles whatever the real clock
   localparam int TLGC_CLK_MHZ = 40;
   localparam int TLGC_DET_UNIT_US = 25;
   localparam int TLGC_DET_UNIT_CYC = TLGC_DET_UNIT_US * TLGC_CLK_MHZ;
   localparam int TLGC_CNT_W = 16;

   // ********************************************
   // Decoded values
   // ********************************************
   localparam logic [3:0] TLGC_LOWKV_DFLT_EXP = 4'h0;
   localparam logic [3:0] TLGC_HIGHKV_DFLT_EXP = 4'h5;
   localparam logic [10:0] TLGC_BW_800 = 11'd800;
   localparam logic [10:0] TLGC_BW_1500 = 11'd1500;
   localparam logic [10:0] TLGC_BW_1000 = 11'd1000;
   localparam logic [10:0] TLGC_BW_500 = 11'd500;
   localparam logic [10:0] TLGC_BW_200 = 11'd200;

   typedef enum logic [3:0] {
      TLGC_AGC12 = 4'h1,
      TLGC_AGC7 = 4'h2,
      TLGC_AGC2 = 4'h4,
      TLGC_FIXED = 4'h8
   } tlgc_method_e;

   typedef enum logic [1:0] {
      TLGC_WR_IDLE = 2'h1,
      TLGC_WR_RESP = 2'h2
   } tlgc_wr_e;

   typedef enum logic [1:0] {
      TLGC_RD_IDLE = 2'h1,
      TLGC_RD_RESP = 2'h2
   } tlgc_rd_e;

endpackage : tlgc_pkg

// ==== tb/tlgc_checker.sv ====
/*
 * Port-level assertions for tlgc_top.
 * Bound from the bench; sees only the top module's ports.
 */
`timescale 1ns/1ps
module tlgc_checker
   import tlgc_pkg::*;
#(
   parameter int DET_UNIT_CYC = 4
)
(
   input wire logic REF_CLK_I,
   input wire logic RST_B_I,
   input wire logic S_AXI_AWVALID_I,
   input wire logic S_AXI_AWREADY_O,
   input wire logic S_AXI_WVALID_I,
   input wire logic S_AXI_WREADY_O,
   input wire logic S_AXI_BVALID_O,
   input wire logic [tlgc_pkg::TLGC_ADDR_W-1:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   input wire logic S_AXI_ARREADY_O,
   input wire logic S_AXI_RVALID_O,
   input wire logic [31:0] S_AXI_RDATA_O,
   input wire logic [3:0] GAIN_METHOD_O,
   input wire logic [3:0] INTEG_GAIN_EXP_O,
   input wire logic [3:0] LOW_KV_EXP_O,
   input wire logic [3:0] HIGH_KV_EXP_O,
   input wire logic COEF_FROM_PRESET_O,
   input wire logic [10:0] BANDWIDTH_HZ_O,
   input wire logic BANDWIDTH_AUTO_O,
   input wire logic PRESET_BAD_O,
   input wire logic DET_TICK_O
);
   // ****************
   // Assertions
   // ****************
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_B_I);
   sequence s_wr_taken;
      S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
   endsequence
   sequence s_cfg_read;
      S_AXI_ARVALID_I && S_AXI_ARREADY_O && S_AXI_ARADDR_I == TLGC_CFG_OFS;
   endsequence
   chk_wr_answer:
      assert property (s_wr_taken |-> ##[1:3] S_AXI_BVALID_O) else $error("no write response");
   chk_rd_answer:
      assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
      else $error("no read response");
   chk_cfg_reserved:
      assert property (s_cfg_read |=> S_AXI_RVALID_O && (S_AXI_RDATA_O & 32'h0888_00E8) == 32'h0)
      else $error("reserved bits read nonzero");
   chk_method_hot:
      assert property ($onehot(GAIN_METHOD_O)) else $error("method not one-hot");
   chk_integ_range:
      assert property (INTEG_GAIN_EXP_O inside {4'hD, 4'hE, 4'hF, [4'h0:4'h4]})
      else $error("integral exponent out of range");
   chk_low_range:
      assert property (LOW_KV_EXP_O inside {[4'hC:4'hF], [4'h0:4'h7]}) else $error("low exp bad");
   chk_high_range:
      assert property (HIGH_KV_EXP_O inside {[4'hC:4'hF], [4'h0:4'h7]}) else $error("high exp bad");
   chk_preset_gate:
      assert property (!COEF_FROM_PRESET_O |-> BANDWIDTH_HZ_O == 11'h0 && !BANDWIDTH_AUTO_O
         && !PRESET_BAD_O) else $error("preset not ignored");
   chk_preset_map:
      assert property (COEF_FROM_PRESET_O |-> (BANDWIDTH_HZ_O == 11'h0)
         == (BANDWIDTH_AUTO_O || PRESET_BAD_O)) else $error("bandwidth map wrong");
   chk_tick_pulse:
      assert property (DET_TICK_O |=> !DET_TICK_O) else $error("tick longer than a cycle");
   // Cycles since the last tick; no period exceeds 32 units
   int gap_cnt;
   always_ff @(posedge REF_CLK_I)
   begin
      if (!RST_B_I || DET_TICK_O)
      begin
         gap_cnt <= 0;
      end
      else
      begin
         gap_cnt <= gap_cnt + 1;
      end
   end
   chk_tick_gap:
      assert property (gap_cnt <= DET_UNIT_CYC * 32) else $error("tick period too long");
endmodule : tlgc_checker

// ==== tb/tlgc_top_tb.sv ====
/*
 * Self-checking bench for tlgc_top: a table of settings, then reserved bit,
 * unmapped address, period and reset cases.
 * Assumes tlgc_checker is compiled alongside.
 */
`timescale 1ns/1ps
module tlgc_top_tb;
   import tlgc_pkg::*;
   // Short unit keeps the longest period at 128 cycles
   localparam int DET_UNIT_CYC = 4;
   typedef struct packed {
      logic [31:0] d;
      logic [3:0] m, ig, lo, hi;
      logic [10:0] bw;
      logic au, bd, cf, ov;
   } tlgc_row_s;
   logic REF_CLK_I = 1'b0, RST_B_I = 1'b0, S_AXI_AWVALID_I = 1'b0, S_AXI_WVALID_I = 1'b0;
   logic S_AXI_BREADY_I = 1'b0, S_AXI_ARVALID_I = 1'b0, S_AXI_RREADY_I = 1'b0;
   logic [7:0] S_AXI_AWADDR_I = 8'h0, S_AXI_ARADDR_I = 8'h0;
   logic [31:0] S_AXI_WDATA_I = 32'h0, S_AXI_RDATA_O;
   logic [3:0] S_AXI_WSTRB_I = 4'hF, GAIN_METHOD_O, INTEG_GAIN_EXP_O, LOW_KV_EXP_O, HIGH_KV_EXP_O;
   logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O, ERROR_WEIGHT_O, PROP_GAIN_O;
   logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O;
   logic PROP_GAIN_QUAD_O, COEF_FROM_PRESET_O, BANDWIDTH_AUTO_O, PRESET_BAD_O;
   logic OVERFLOW_RISK_O, DET_TICK_O;
   logic [10:0] BANDWIDTH_HZ_O;
   int fails = 0, total_checks = 0, cyc = 0, n;
   int mult [8] = '{2, 4, 8, 1, 16, 32, 2, 2};
   // high gain kept above low gain
   tlgc_row_s rows [12] = '{
      '{32'h0002_0010, 4'h1, 4'h0, 4'h0, 4'h5, 11'd800, 1'b0, 1'b0, 1'b1, 1'b0},
      '{32'h4010_1211, 4'h2, 4'hD, 4'hC, 4'hD, 11'd0, 1'b0, 1'b1, 1'b1, 1'b0},
      '{32'h8020_5A12, 4'h4, 4'hE, 4'h0, 4'h5, 11'd0, 1'b0, 1'b1, 1'b1, 1'b0},
      '{32'hC030_BC13, 4'h8, 4'hF, 4'h6, 4'h7, 11'd1500, 1'b0, 1'b0, 1'b1, 1'b0},
      '{32'h0040_DD14, 4'h1, 4'h1, 4'h0, 4'h5, 11'd1000, 1'b0, 1'b0, 1'b1, 1'b0},
      '{32'h0050_FF15, 4'h1, 4'h2, 4'h0, 4'h5, 11'd500, 1'b0, 1'b0, 1'b1, 1'b0},
      '{32'h0060_6B16, 4'h1, 4'h3, 4'h1, 4'h6, 11'd200, 1'b0, 1'b0, 1'b1, 1'b0},
      '{32'h0070_EE17, 4'h1, 4'h4, 4'h0, 4'h5, 11'd0, 1'b1, 1'b0, 1'b1, 1'b0},
      '{32'h0000_0007, 4'h1, 4'h0, 4'h0, 4'h5, 11'd0, 1'b0, 1'b0, 1'b0, 1'b0},
      '{32'h0700_0010, 4'h1, 4'h0, 4'h0, 4'h5, 11'd800, 1'b0, 1'b0, 1'b1, 1'b1},
      '{32'h9700_0B10, 4'h4, 4'h0, 4'h0, 4'h6, 11'd800, 1'b0, 1'b0, 1'b1, 1'b1},
      '{32'h9700_0A10, 4'h4, 4'h0, 4'h0, 4'h5, 11'd800, 1'b0, 1'b0, 1'b1, 1'b0}};

   tlgc_top #(.DET_UNIT_CYC(DET_UNIT_CYC)) dut (
      .REF_CLK_I(REF_CLK_I), .RST_B_I(RST_B_I), .S_AXI_AWADDR_I(S_AXI_AWADDR_I),
      .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
      .S_AXI_WDATA_I(S_AXI_WDATA_I), .S_AXI_WSTRB_I(S_AXI_WSTRB_I),
      .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
      .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
      .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARADDR_I(S_AXI_ARADDR_I),
      .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
      .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RRESP_O(S_AXI_RRESP_O),
      .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
      .GAIN_METHOD_O(GAIN_METHOD_O), .INTEG_GAIN_EXP_O(INTEG_GAIN_EXP_O),
      .LOW_KV_EXP_O(LOW_KV_EXP_O), .HIGH_KV_EXP_O(HIGH_KV_EXP_O),
      .ERROR_WEIGHT_O(ERROR_WEIGHT_O), .PROP_GAIN_O(PROP_GAIN_O),
      .PROP_GAIN_QUAD_O(PROP_GAIN_QUAD_O), .COEF_FROM_PRESET_O(COEF_FROM_PRESET_O),
      .BANDWIDTH_HZ_O(BANDWIDTH_HZ_O), .BANDWIDTH_AUTO_O(BANDWIDTH_AUTO_O),
      .PRESET_BAD_O(PRESET_BAD_O), .OVERFLOW_RISK_O(OVERFLOW_RISK_O), .DET_TICK_O(DET_TICK_O));

   initial
   begin
      forever #25 REF_CLK_I = ~REF_CLK_I;
   end

   // ****************
   // Tasks
   // ****************
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e)
      begin
         fails++;
         $display("mismatch at %0t: saw %h want %h", $time, s, e);
      end
   endtask : chk

   task print_verdict;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict

   // Ready is sampled at the edge itself, before the edge's updates land
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw;
      logic w;
      aw = 1'b0;
      w = 1'b0;
      S_AXI_AWADDR_I <= a;
      S_AXI_WDATA_I <= d;
      S_AXI_BREADY_I <= 1'b1;
      while (!(aw && w))
      begin
         S_AXI_AWVALID_I <= !aw;
         S_AXI_WVALID_I <= !w;
         @(posedge REF_CLK_I);
         aw = aw || (S_AXI_AWVALID_I && S_AXI_AWREADY_O);
         w = w || (S_AXI_WVALID_I && S_AXI_WREADY_O);
      end
      S_AXI_AWVALID_I <= 1'b0;
      S_AXI_WVALID_I <= 1'b0;
      do @(posedge REF_CLK_I); while (!S_AXI_BVALID_O);
      S_AXI_BREADY_I <= 1'b0;
      chk(32'(S_AXI_BRESP_O), 32'(er));
      @(posedge REF_CLK_I);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
      S_AXI_ARADDR_I <= a;
      S_AXI_ARVALID_I <= 1'b1;
      S_AXI_RREADY_I <= 1'b1;
      do @(posedge REF_CLK_I); while (!S_AXI_ARREADY_O);
      S_AXI_ARVALID_I <= 1'b0;
      do @(posedge REF_CLK_I); while (!S_AXI_RVALID_O);
      S_AXI_RREADY_I <= 1'b0;
      chk(S_AXI_RDATA_O, ed);
      chk(32'(S_AXI_RRESP_O), 32'(er));
      @(posedge REF_CLK_I);
   endtask : rd

   task automatic chk_row(input tlgc_row_s r);
      chk(32'(GAIN_METHOD_O), 32'(r.m));
      chk(32'(INTEG_GAIN_EXP_O), 32'(r.ig));
      chk(32'(LOW_KV_EXP_O), 32'(r.lo));
      chk(32'(HIGH_KV_EXP_O), 32'(r.hi));
      chk(32'(BANDWIDTH_HZ_O), 32'(r.bw));
      chk(32'({BANDWIDTH_AUTO_O, PRESET_BAD_O}), 32'({r.au, r.bd}));
      chk(32'(COEF_FROM_PRESET_O), 32'(r.cf));
      chk(32'(OVERFLOW_RISK_O), 32'(r.ov));
   endtask : chk_row

   always @(posedge REF_CLK_I)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fails++;
         print_verdict();
      end
   end

   // ****************
   // Sequence
   // ****************
   initial
   begin
      repeat (5) @(posedge REF_CLK_I);
      RST_B_I <= 1'b1;
      repeat (2) @(posedge REF_CLK_I);
      chk_row(rows[0]);
      foreach (rows[i])
      begin
         wr(TLGC_CFG_OFS, rows[i].d, TLGC_RESP_OKAY);
         @(posedge REF_CLK_I);
         chk_row(rows[i]);
         rd(TLGC_CFG_OFS, TLGC_RESP_OKAY, rows[i].d);
      end
      wr(TLGC_CFG_OFS, 32'hFFFF_FFFF, TLGC_RESP_OKAY);
      rd(TLGC_CFG_OFS, TLGC_RESP_OKAY, 32'hF777_FF17);
      chk(32'({ERROR_WEIGHT_O, PROP_GAIN_QUAD_O, PROP_GAIN_O}), 32'h1F);
      wr(8'h10, 32'h1234_5678, TLGC_RESP_SLVERR);
      wr(TLGC_STAT_OFS, 32'h0, TLGC_RESP_SLVERR);
      rd(8'h10, TLGC_RESP_SLVERR, 32'h0);
      rd(TLGC_STAT_OFS, TLGC_RESP_OKAY, 32'h0000_C504);
      chk(32'(TLGC_DET_UNIT_CYC * 2), 32'd2000);
      // no excitation here, every period code timed
      for (int c = 0; c < 8; c++)
      begin
         wr(TLGC_CFG_OFS, {13'h0, 3'(c), 16'h0010}, TLGC_RESP_OKAY);
         // First ticks may still run on the old period
         repeat (2) do @(posedge REF_CLK_I); while (!DET_TICK_O);
         n = 0;
         do
         begin
            @(posedge REF_CLK_I);
            n++;
         end
         while (!DET_TICK_O);
         chk(32'(n), 32'(DET_UNIT_CYC * mult[c]));
      end
      wr(TLGC_CFG_OFS, rows[3].d, TLGC_RESP_OKAY);
      RST_B_I <= 1'b0;
      repeat (5) @(posedge REF_CLK_I);
      RST_B_I <= 1'b1;
      repeat (2) @(posedge REF_CLK_I);
      chk_row(rows[0]);
      rd(TLGC_CFG_OFS, TLGC_RESP_OKAY, 32'h0002_0010);
      // Only byte one may land
      S_AXI_WSTRB_I <= 4'h2;
      wr(TLGC_CFG_OFS, 32'hFFFF_5A00, TLGC_RESP_OKAY);
      rd(TLGC_CFG_OFS, TLGC_RESP_OKAY, 32'h0002_5A10);
      print_verdict();
   end
endmodule : tlgc_top_tb

bind tlgc_top tlgc_checker #(.DET_UNIT_CYC(DET_UNIT_CYC)) u_chk (
   .REF_CLK_I(REF_CLK_I), .RST_B_I(RST_B_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I),
   .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WVALID_I(S_AXI_WVALID_I),
   .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
   .S_AXI_ARADDR_I(S_AXI_ARADDR_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
   .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
   .S_AXI_RDATA_O(S_AXI_RDATA_O), .GAIN_METHOD_O(GAIN_METHOD_O),
   .INTEG_GAIN_EXP_O(INTEG_GAIN_EXP_O), .LOW_KV_EXP_O(LOW_KV_EXP_O),
   .HIGH_KV_EXP_O(HIGH_KV_EXP_O), .COEF_FROM_PRESET_O(COEF_FROM_PRESET_O),
   .BANDWIDTH_HZ_O(BANDWIDTH_HZ_O), .BANDWIDTH_AUTO_O(BANDWIDTH_AUTO_O),
   .PRESET_BAD_O(PRESET_BAD_O), .DET_TICK_O(DET_TICK_O));
